// file: inc/dmi_pkg.sv
/*
  Shared constants and types for the DDR2 mode-set decoder.
  Assumes a single core clock at 100 MHz that stands for the memory clock crossing.
*/
// How it works
// - Sample inputs on rising true-clock crossing
// - Clock enable gates internal clocking circuitry
// - Mode writes never touch array contents
// - All strobes low, banks zero: mode set
// - Mode rewrite accepted when all banks precharged
// - Burst length from A[2:0], 4 or 8
// - Burst ordering type from A3
// - Column latency from A[6:4]
// - Write recovery from A[11:9]
package dmi_pkg;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  // Bank select codes that steer a mode-set command
  localparam logic [1:0] BANK_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT1 = 2'h1;
  localparam logic [1:0] BANK_EXT2 = 2'h2;
  localparam logic [1:0] BANK_EXT3 = 2'h3;
  // Field positions in the operating mode register
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int TM_BIT = 7;
  localparam int DLLRST_BIT = 8;
  localparam int WR_LSB = 9;
  // Field positions in extended register one
  localparam int DLLDIS_BIT = 0;
  localparam int CAL_LSB = 7;
  // Burst length codes, calibration codes and the register reset value
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;
  localparam logic [12:0] MODE_RESET = 13'h0000;
  // Loop lock wait after a loop reset, in memory clocks
  localparam int LOCK_CYCLES = 200;
  // Command pins, all active low
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dmi_cmd_t;
  typedef struct packed {
    dmi_cmd_t cmd;
    logic [1:0] bank;
    logic [12:0] addr;
    logic clk_en;
    logic on_die_termination;
  } dmi_pins_t;
  // Decoded operating parameters
  typedef struct packed {
    logic [3:0] burst_len;
    logic burst_interleave;
    logic [2:0] cas_lat;
    logic test_mode;
    logic [2:0] write_rec;
  } dmi_mode_t;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h7,
    CMD_MODE = 4'h0,
    CMD_REFRESH = 4'h1,
    CMD_PRECHARGE = 4'h2,
    CMD_ACTIVATE = 4'h3
  } dmi_op_t;
endpackage

// file: src/dmi_sync.sv
/*
  Two-flop synchroniser for a bus of pins.
  Assumes the inputs are asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module dmi_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // First stage only feeds the second
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule // dmi_sync
`default_nettype wire

// file: src/dmi_mode_ctl.sv
/*
  Device-side command decoder for mode and extended mode writes of a
  four-bank DDR2 memory, plus the settings those writes steer.
  Assumes the controller keeps the power-up order and timing; pins are
  asynchronous and are synchronised before use.
*/
`timescale 1ns/1ps
`default_nettype none
module dmi_mode_ctl #(
  parameter int LOCK_WAIT = dmi_pkg::LOCK_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire dmi_pkg::dmi_pins_t pins_i,
  output dmi_pkg::dmi_mode_t mode_o,
  output logic [12:0] ext1_o,
  output logic [12:0] ext2_o,
  output logic [12:0] ext3_o,
  output logic clk_run_o,
  output logic odt_on_o,
  output logic loop_on_o,
  output logic loop_locked_o,
  output logic cal_default_o,
  output logic ready_o,
  output logic illegal_o
);
  import dmi_pkg::*;

  localparam int PW = $bits(dmi_pins_t);

  ////////////////////////////////////////////////////////////////////
  // Pin capture: two flops, then one sample per rising crossing
  dmi_pins_t pins_s;
  logic [PW-1:0] pins_raw;
  dmi_sync #(.W(PW)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(pins_i),
    .q_o(pins_raw)
  );
  assign pins_s = dmi_pins_t'(pins_raw);

  // Command decode used by several processes
  function automatic logic is_cmd(input dmi_cmd_t c, input dmi_op_t op);
    return {c.cs_n, c.ras_n, c.cas_n, c.we_n} == 4'(op);
  endfunction

  // Burst length code to beats; unsupported codes give zero
  function automatic logic [3:0] bl_beats(input logic [2:0] code);
    unique case (code)
      BL_CODE_4: bl_beats = 4'h4;
      BL_CODE_8: bl_beats = 4'h8;
      default: bl_beats = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Register state
  logic [12:0] mr_q, mr_d;
  logic [12:0] e1_q, e1_d, e2_q, e2_d, e3_q, e3_d;
  logic cke_q, cke_d;
  logic [NUM_BANKS-1:0] open_q, open_d;
  logic [7:0] lock_q, lock_d;
  logic locked_q, locked_d;
  logic ready_q, ready_d;
  logic bad_q, bad_d;
  logic odt_q, odt_d;
  logic lon_q, lon_d;
  logic cdef_q, cdef_d;
  logic cmd_valid;
  logic mode_wr;

  // Clock enable gates every command; deselect is ignored
  assign cmd_valid = cke_q && !pins_s.cmd.cs_n;
  // Mode writes only taken with all banks precharged
  assign mode_wr = cmd_valid && is_cmd(pins_s.cmd, CMD_MODE) && (open_q == '0);

  // Next-state for registers, bank tracking and loop lock
  always_comb begin
    mr_d = mr_q;
    e1_d = e1_q;
    e2_d = e2_q;
    e3_d = e3_q;
    open_d = open_q;
    lock_d = lock_q;
    locked_d = locked_q;
    ready_d = ready_q;
    bad_d = 1'b0;
    cke_d = pins_s.clk_en;
    odt_d = pins_s.on_die_termination && cke_q;
    // Whole register is replaced, never merged
    if (mode_wr) begin
      unique case (pins_s.bank)
        BANK_MODE: mr_d = pins_s.addr;
        BANK_EXT1: e1_d = pins_s.addr;
        BANK_EXT2: e2_d = pins_s.addr;
        BANK_EXT3: e3_d = pins_s.addr;
      endcase
    end
    // Illegal: mode write with a bank open
    if (cmd_valid && is_cmd(pins_s.cmd, CMD_MODE) && (open_q != '0)) begin
      bad_d = 1'b1;
    end
    // Bank open/close tracking; array contents not modelled, never cleared
    if (cmd_valid && is_cmd(pins_s.cmd, CMD_ACTIVATE)) begin
      open_d[pins_s.bank] = 1'b1;
    end
    if (cmd_valid && is_cmd(pins_s.cmd, CMD_PRECHARGE)) begin
      if (pins_s.addr[10]) begin
        open_d = '0;
      end else begin
        open_d[pins_s.bank] = 1'b0;
      end
    end
    // Loop reset restarts the lock count; array untouched
    if (mode_wr && pins_s.bank == BANK_MODE && pins_s.addr[DLLRST_BIT]) begin
      lock_d = 8'(LOCK_WAIT);
      locked_d = 1'b0;
      ready_d = 1'b0;
    end else if (cke_q && lock_q != 8'h00) begin
      lock_d = lock_q - 8'h01;
      locked_d = (lock_q == 8'h01);
    end
    // Calibration exit write marks the device ready
    if (mode_wr && pins_s.bank == BANK_EXT1 && locked_q &&
        pins_s.addr[CAL_LSB+:3] == CAL_EXIT && e1_q[CAL_LSB+:3] == CAL_DEFAULT) begin
      ready_d = 1'b1;
    end
    // Flags taken from the next ext1 value so both outputs leave flops
    lon_d = !e1_d[DLLDIS_BIT];
    cdef_d = (e1_d[CAL_LSB+:3] == CAL_DEFAULT);
  end

  // Registers only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mr_q <= MODE_RESET;
      e1_q <= MODE_RESET;
      e2_q <= MODE_RESET;
      e3_q <= MODE_RESET;
      cke_q <= 1'b0;
      open_q <= '0;
      lock_q <= 8'h00;
      locked_q <= 1'b0;
      ready_q <= 1'b0;
      bad_q <= 1'b0;
      odt_q <= 1'b0;
      lon_q <= 1'b1;
      cdef_q <= 1'b0;
    end else begin
      mr_q <= mr_d;
      e1_q <= e1_d;
      e2_q <= e2_d;
      e3_q <= e3_d;
      cke_q <= cke_d;
      open_q <= open_d;
      lock_q <= lock_d;
      locked_q <= locked_d;
      ready_q <= ready_d;
      bad_q <= bad_d;
      odt_q <= odt_d;
      lon_q <= lon_d;
      cdef_q <= cdef_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs straight from flops; decoded fields are registered from the next mode value
  dmi_mode_t mode_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= '0;
    end else begin
      mode_q.burst_len <= bl_beats(mr_d[BL_LSB+:3]);
      mode_q.burst_interleave <= mr_d[BT_BIT];
      mode_q.cas_lat <= mr_d[CL_LSB+:3];
      mode_q.test_mode <= mr_d[TM_BIT];
      mode_q.write_rec <= mr_d[WR_LSB+:3];
    end
  end

  assign mode_o = mode_q;
  assign ext1_o = e1_q;
  assign ext2_o = e2_q;
  assign ext3_o = e3_q;
  assign clk_run_o = cke_q;
  assign odt_on_o = odt_q;
  assign loop_on_o = lon_q;
  assign loop_locked_o = locked_q;
  assign cal_default_o = cdef_q;
  assign ready_o = ready_q;
  assign illegal_o = bad_q;

  ////////////////////////////////////////////////////////////////////
  // Checks
  mode_capture_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mode_wr && pins_s.bank == BANK_MODE |=> mr_q == $past(pins_s.addr))
    else $error("mode register not loaded");
  blocked_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cmd_valid && is_cmd(pins_s.cmd, CMD_MODE) && open_q != '0 |=> $stable(mr_q) && bad_q)
    else $error("mode write taken with bank open");
  clock_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !cke_q |=> $stable(mr_q) && $stable(e1_q))
    else $error("write taken with clock enable low");
  // Decode held against the code constants, not against the decode function
  burst_len_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ##1 mode_q.burst_len == ((mr_q[BL_LSB+:3] == BL_CODE_8) ? 4'h8 :
    (mr_q[BL_LSB+:3] == BL_CODE_4) ? 4'h4 : 4'h0))
    else $error("burst length decode wrong");
  field_map_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ##1 mode_q.cas_lat == mr_q[CL_LSB+:3] && mode_q.write_rec == mr_q[WR_LSB+:3]
    && mode_q.burst_interleave == mr_q[BT_BIT] && mode_q.test_mode == mr_q[TM_BIT])
    else $error("mode field decode wrong");
  // Three clocks is safe for any lock wait of four or more; lock_done_a pins the end
  lock_wait_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mode_wr && pins_s.bank == BANK_MODE && pins_s.addr[DLLRST_BIT] |=> !locked_q[*3])
    else $error("loop locked too early");
  lock_done_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(locked_q) |-> $past(lock_q) == 8'h01)
    else $error("loop lock count ended early");
  sample_lag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ##3 cke_q == $past(pins_i.clk_en, 3))
    else $error("clock enable sample lag wrong");
  ready_order_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(ready_q) |-> $past(locked_q))
    else $error("ready before loop locked");
  cov_mode_c: cover property (@(posedge core_clk_i) mode_wr && pins_s.bank == BANK_MODE);
  cov_ext1_c: cover property (@(posedge core_clk_i) mode_wr && pins_s.bank == BANK_EXT1);
  cov_ready_c: cover property (@(posedge core_clk_i) $rose(ready_q));
  cov_bad_c: cover property (@(posedge core_clk_i) bad_q);
endmodule // dmi_mode_ctl
`default_nettype wire

// file: sim/dmi_ctl_model.sv
/*
  Controller-side pin driver facing the mode decoder.
  Assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/1ps
`default_nettype none
module dmi_ctl_model (
  input wire logic core_clk_i,
  output dmi_pkg::dmi_pins_t pins_o
);
  import dmi_pkg::*;
  // Idle: deselect, enable and termination low
  initial pins_o = {4'hf, 2'h0, 13'h0000, 1'b0, 1'b0};
  ////////////////////////////////////////
  // Level change on enable and termination
  task automatic lvl(input logic cke, input logic on_die_termination);
    @(negedge core_clk_i);
    pins_o.clk_en <= cke;
    pins_o.on_die_termination <= on_die_termination;
  endtask
  // One command cycle, then deselect; freed lines flip so stale values never pass
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(negedge core_clk_i);
    pins_o.cmd <= c;
    pins_o.bank <= b;
    pins_o.addr <= a;
    @(negedge core_clk_i);
    pins_o.cmd <= 4'hf;
    pins_o.bank <= ~b;
    pins_o.addr <= ~a;
  endtask
endmodule // dmi_ctl_model
`default_nettype wire

// file: sim/testbench.sv
/*
  Self-checking bench for the mode decoder: notes queued, checked later.
  Assumes three clock edges from a pin change to the register outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dmi_pkg::*;
  typedef struct packed {
    dmi_mode_t m;
    logic [12:0] a, b, c;
    logic [6:0] f;
  } dmi_snap_t;
  typedef struct {int due; dmi_snap_t s;} dmi_note_t;
  dmi_note_t q[$];
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  dmi_pins_t pins;
  dmi_mode_t mode;
  logic [12:0] e1o, e2o, e3o;
  logic run, odto, lon, llk, cdef, rdy, ill, ils = 1'b0;
  int err_total = 0, cmp_count = 0, cyc = 0;
  logic [31:0] rs = 32'h0000000d;
  logic [12:0] mr = 13'h0000, x1 = 13'h0000, x2 = 13'h0000, x3 = 13'h0000;
  logic en = 1'b0, od = 1'b0, lck = 1'b0, rd = 1'b0, il = 1'b0;
  logic [3:0] opn = 4'h0;
  // Short lock wait keeps the run brief; must stay at four or more
  localparam int LOCK_T = 4;
  dmi_ctl_model i_ctl (.core_clk_i(core_clk_i), .pins_o(pins));
  dmi_mode_ctl #(.LOCK_WAIT(LOCK_T)) i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .pins_i(pins), .mode_o(mode), .ext1_o(e1o), .ext2_o(e2o), .ext3_o(e3o),
    .clk_run_o(run), .odt_on_o(odto), .loop_on_o(lon), .loop_locked_o(llk),
    .cal_default_o(cdef), .ready_o(rdy), .illegal_o(ill));
  ////////////////////////////////////////
  // Free-running core clock
  initial forever #5 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Expected outputs from the bench's own register copy
  function automatic dmi_snap_t exp_s();
    dmi_snap_t s;
    s.m.burst_len = (mr[2:0] == 3'h2) ? 4'h4 : (mr[2:0] == 3'h3) ? 4'h8 : 4'h0;
    s.m.burst_interleave = mr[3];
    s.m.cas_lat = mr[6:4];
    s.m.test_mode = mr[7];
    s.m.write_rec = mr[11:9];
    s.a = x1;
    s.b = x2;
    s.c = x3;
    s.f = {en, od & en, ~x1[0], x1[9:7] == 3'h7, lck, rd, il};
    return s;
  endfunction
  task automatic end_of_test();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input dmi_snap_t e);
    dmi_snap_t g;
    g = {mode, e1o, e2o, e3o, run, odto, lon, cdef, llk, rdy, ils};
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Note, then wait under a bound until the monitor has used it
  task automatic push();
    int n;
    q.push_back('{cyc + 5, exp_s()});
    il = 1'b0;
    for (n = 0; n < 50 && q.size() > 0; n++) @(negedge core_clk_i);
    if (q.size() > 0) begin
      err_total++;
      $display("BAD %0t no result", $time);
      end_of_test();
    end
  endtask
  task automatic lv(input logic c, input logic o);
    i_ctl.lvl(c, o);
    en = c;
    od = o;
    push();
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    logic lr;
    lr = 1'b0;
    i_ctl.issue(c, b, a);
    if (en) begin
      if (c == 4'h3) opn[b] = 1'b1;
      if (c == 4'h2) begin
        if (a[10]) opn = 4'h0;
        else opn[b] = 1'b0;
      end
      if (c == 4'h0 && opn != 4'h0) il = 1'b1;
      else if (c == 4'h0) case (b)
        2'h0: begin
          mr = a;
          if (a[8]) begin
            {rd, lck} = 2'b00;
            lr = 1'b1;
          end
        end
        2'h1: begin
          if (a[9:7] == 3'h0 && x1[9:7] == 3'h7 && lck) rd = 1'b1;
          x1 = a;
        end
        2'h2: x2 = a;
        default: x3 = a;
      endcase
    end
    push();
    // Lock lands LOCK_T enabled clocks after the loop reset is decoded
    if (lr) begin
      repeat (LOCK_T) @(negedge core_clk_i);
      lck = 1'b1;
      push();
    end
  endtask
  // Monitor: latch one-cycle refusal pulses, check the oldest note once due
  always @(negedge core_clk_i) begin : mon
    dmi_note_t n;
    cyc++;
    if (ill === 1'b1) ils = 1'b1;
    if (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      chk(n.s);
      ils = 1'b0;
    end
  end
  // Power-up order, field decode, refusals, enable gating
  initial begin
    logic [31:0] a;
    repeat (20) @(negedge core_clk_i);
    rst_i = 1'b0;
    push();
    repeat (20000) @(negedge core_clk_i);
    lv(1'b1, 1'b0);
    repeat (40) @(negedge core_clk_i);
    cmd(4'h2, 2'h0, 13'h0400);
    cmd(4'h0, 2'h2, 13'h0000);
    cmd(4'h0, 2'h3, 13'h0000);
    cmd(4'h0, 2'h1, 13'h0000);
    cmd(4'h0, 2'h0, 13'h0132);
    cmd(4'h2, 2'h0, 13'h0400);
    cmd(4'h1, 2'h0, 13'h0000);
    cmd(4'h1, 2'h0, 13'h0000);
    cmd(4'h0, 2'h0, 13'h0a33);
    repeat (200) @(negedge core_clk_i);
    lck = 1'b1;
    cmd(4'h0, 2'h1, 13'h0380);
    cmd(4'h0, 2'h1, 13'h0000);
    lv(1'b1, 1'b1);
    lv(1'b1, 1'b0);
    for (int k = 0; k < 8; k++) begin
      a = rnd();
      a[2:0] = 3'(k);
      a[8:7] = 2'h0;
      cmd(4'h0, 2'h0, a[12:0]);
    end
    a = rnd();
    cmd(4'h3, 2'h1, a[12:0]);
    cmd(4'h0, 2'h0, 13'h0032);
    cmd(4'h0, 2'h3, 13'h0000);
    cmd(4'h2, 2'h0, 13'h0000);
    cmd(4'h0, 2'h0, 13'h0032);
    cmd(4'h2, 2'h0, 13'h0400);
    cmd(4'h0, 2'h0, 13'h0032);
    lv(1'b0, 1'b1);
    cmd(4'h0, 2'h0, 13'h0123);
    lv(1'b1, 1'b0);
    cmd(4'h0, 2'h0, 13'h0102);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
